// ### common/move_ops_pkg.sv
// package: opcodes, field layout, reset values and register map
`default_nettype none
package move_ops_pkg;
    localparam int NIBBLE_W = 4;
    localparam int ADDR_W   = 7;
    localparam int PORTS    = 4;
    typedef logic [NIBBLE_W-1:0] nibble_t;
    typedef logic [ADDR_W-1:0]   maddr_t;
    typedef nibble_t [PORTS-1:0] port_nibbles_t;

    // port indexes inside port_nibbles_t
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;

    // instruction fields
    localparam int ADDR_LSB   = 0;
    localparam int FIELD_LSB  = 7;
    localparam int PREFIX_LSB = 7;
    localparam int WSEL_LSB   = 8;
    localparam int SEF_LSB    = 0;

    // opcode prefixes; the nine-bit ones are followed by a 7-bit address
    localparam logic [8:0] OP_STORE_ACC = 9'h0B3;
    localparam logic [8:0] OP_IN_PORT_C = 9'h096;
    localparam logic [8:0] OP_IN_PORT_D = 9'h097;
    localparam logic [8:0] OP_OUT_A     = 9'h0B4;
    localparam logic [8:0] OP_OUT_B     = 9'h0B5;
    localparam logic [8:0] OP_OUT_C     = 9'h118;
    localparam logic [8:0] OP_OUT_D     = 9'h119;
    localparam logic [3:0] OP_STORE_WR  = 4'hF;
    localparam logic [4:0] OP_STORE_IMM = 5'h17;
    localparam logic [11:0] OP_SET_WAKE = 12'h4E0;

    // reset values
    localparam nibble_t DIR_MASK_RESET    = 4'hF;
    localparam nibble_t WAKE_ENABLE_RESET = 4'h0;
    localparam nibble_t LATCH_RESET       = 4'h0;

    // register byte offsets
    localparam logic [7:0] REG_DIR_MASK   = 8'h00;
    localparam logic [7:0] REG_CORE_STATE = 8'h04;
    localparam logic [7:0] REG_OUT_LATCH  = 8'h08;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef struct packed {
        nibble_t data;
        nibble_t oe_n;
    } port_drive_t;
endpackage
`default_nettype wire

// ### hw/data_memory.sv
// nibble data memory, one write port, one asynchronous read port
`timescale 1ns/100ps
`default_nettype none
module data_memory
    import move_ops_pkg::*;
#(
    parameter int DEPTH = 128
) (
    input  wire logic    clk_sys,
    input  wire logic    write_en,
    input  wire maddr_t  write_addr,
    input  wire nibble_t write_data,
    input  wire maddr_t  read_addr,
    output logic         unused_ok,
    output nibble_t      read_data
);
    nibble_t cells [DEPTH];

    // contents are not cleared by reset, as in the core's RAM
    always_ff @(posedge clk_sys) begin
        if (write_en) begin
            cells[write_addr] <= write_data;
        end
    end

    assign read_data = cells[read_addr];
    assign unused_ok = 1'b1;
endmodule
`default_nettype wire

// ### hw/wake_detector.sv
// falling-edge wake detector for the port_c pins in stop mode
`timescale 1ns/100ps
`default_nettype none
module wake_detector
    import move_ops_pkg::*;
(
    input  wire logic    clk_sys,
    input  wire logic    reset,
    input  wire logic    stop_mode,
    input  wire nibble_t pin_level,
    input  wire nibble_t edge_enable,
    output logic         wake_request
);
    nibble_t last_level;
    nibble_t fell;

    genvar i;
    generate
        for (i = 0; i < NIBBLE_W; i++) begin : g_pin
            assign fell[i] = last_level[i] & ~pin_level[i] & edge_enable[i];
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            last_level   <= 4'hF;
            wake_request <= 1'b0;
        end else begin
            last_level   <= pin_level;
            wake_request <= stop_mode & (|fell);
        end
    end
endmodule
`default_nettype wire

// ### hw/port_and_memory_move_ops.sv
// data-move instruction group: memory stores, port moves, wake enables
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// (RULE1) prefix 010110011 stores the accumulator into the addressed nibble.
// (RULE2) prefix 010010110 loads port_c pins into memory and accumulator.
// (RULE3) prefix 010010111 loads port_d pins into memory and accumulator.
// (RULE4) leading 1111 copies the selected working register to memory.
// (RULE5) leading 10111 writes a 4-bit immediate to memory.
// (RULE6) prefix 010110100 puts the addressed nibble on the port_a latch.
// (RULE7) prefix 010110101 puts the addressed nibble on the port_b latch.
// (RULE8) prefix 100011000 puts the addressed nibble on the port_c latch.
// (RULE9) prefix 100011001 puts the addressed nibble on the port_d latch.
// (RULE10) wake-enable instruction: each bit lets a port_c falling edge wake.
// (RULE11) direction mask bit 0 drives the pin; masks reset to all ones.
// (RULE12) port-input moves set zero_flag when the loaded nibble is zero.
module port_and_memory_move_ops
    import move_ops_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          reset,
    input  wire logic          instr_valid,
    input  wire logic [15:0]   instr,
    input  wire logic          core_acc_we,
    input  wire nibble_t       core_acc_data,
    input  wire logic          stop_mode,
    input  wire port_nibbles_t pin_in,
    output port_drive_t        pin_drive [PORTS],
    output nibble_t            accumulator,
    output logic               zero_flag,
    output nibble_t            stop_wake_edge_enable,
    output logic               wake_request,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic [31:0]        hrdata,
    output logic               hresp
);
    typedef struct packed {
        nibble_t       acc;
        logic          zero;
        nibble_t       wake_en;
        port_nibbles_t dir_mask;
        port_nibbles_t out_latch;
        logic          wr_pend;
        logic [7:0]    wr_addr;
        logic [31:0]   rdata;
    } state_t;

    state_t state;
    state_t next_state;

    // decode
    logic [8:0] prefix;
    maddr_t     mem_addr;
    nibble_t    field;
    logic       is_store_acc;
    logic       is_in_c;
    logic       is_in_d;
    logic       is_store_wr;
    logic       is_store_imm;
    logic       is_out_a;
    logic       is_out_b;
    logic       is_out_c;
    logic       is_out_d;
    logic       is_set_wake;

    assign prefix   = instr[PREFIX_LSB +: 9];
    assign mem_addr = instr[ADDR_LSB +: ADDR_W];
    assign field    = instr[FIELD_LSB +: NIBBLE_W];

    assign is_store_acc = instr_valid && prefix == OP_STORE_ACC; // RULE1
    assign is_in_c      = instr_valid && prefix == OP_IN_PORT_C; // RULE2
    assign is_in_d      = instr_valid && prefix == OP_IN_PORT_D; // RULE3
    assign is_store_wr  = instr_valid && instr[15:12] == OP_STORE_WR; // RULE4
    assign is_store_imm = instr_valid && instr[15:11] == OP_STORE_IMM; // RULE5
    assign is_out_a     = instr_valid && prefix == OP_OUT_A; // RULE6
    assign is_out_b     = instr_valid && prefix == OP_OUT_B; // RULE7
    assign is_out_c     = instr_valid && prefix == OP_OUT_C; // RULE8
    assign is_out_d     = instr_valid && prefix == OP_OUT_D; // RULE9
    assign is_set_wake  = instr_valid && instr[15:4] == OP_SET_WAKE; // RULE10

    // memory ports
    logic    mem_we;
    nibble_t mem_wdata;
    maddr_t  mem_raddr;
    nibble_t mem_rdata;
    nibble_t port_sample;

    // working registers sit in the lowest sixteen memory nibbles
    assign mem_raddr = is_store_wr ? {3'h0, instr[WSEL_LSB +: NIBBLE_W]}
                                   : mem_addr;
    assign port_sample = is_in_d ? pin_in[PORT_D] : pin_in[PORT_C];

    always_comb begin
        mem_we    = 1'b0;
        mem_wdata = state.acc;
        if (is_store_acc) begin
            mem_we    = 1'b1; // RULE1
            mem_wdata = state.acc;
        end else if (is_in_c || is_in_d) begin
            mem_we    = 1'b1; // RULE2 RULE3
            mem_wdata = port_sample;
        end else if (is_store_wr) begin
            mem_we    = 1'b1; // RULE4
            mem_wdata = mem_rdata;
        end else if (is_store_imm) begin
            mem_we    = 1'b1; // RULE5
            mem_wdata = field;
        end
    end

    data_memory #(.DEPTH(128)) u_mem (
        .clk_sys    (clk_sys),
        .write_en   (mem_we),
        .write_addr (mem_addr),
        .write_data (mem_wdata),
        .read_addr  (mem_raddr),
        .unused_ok  (),
        .read_data  (mem_rdata)
    );

    wake_detector u_wake (
        .clk_sys      (clk_sys),
        .reset        (reset),
        .stop_mode    (stop_mode),
        .pin_level    (pin_in[PORT_C]),
        .edge_enable  (state.wake_en), // RULE10
        .wake_request (wake_request)
    );

    // ahb-lite slave, zero wait states
    logic       bus_take;
    logic [7:0] bus_addr;
    logic       addr_hit;
    logic [31:0] read_word;

    assign bus_take = hsel && hready && htrans == HTRANS_NONSEQ;
    assign bus_addr = haddr[7:0];
    assign addr_hit = haddr[31:8] == 24'h000000;

    always_comb begin
        read_word = 32'h00000000;
        if (addr_hit) begin
            unique case (bus_addr)
                REG_DIR_MASK:   read_word = {16'h0000, state.dir_mask};
                REG_CORE_STATE: read_word = {20'h00000, state.wake_en,
                                             3'h0, state.zero, state.acc};
                REG_OUT_LATCH:  read_word = {16'h0000, state.out_latch};
                default:        read_word = 32'h00000000;
            endcase
        end
    end

    always_comb begin
        next_state = state;
        // bus write lands in its data phase
        next_state.wr_pend = bus_take && hwrite && addr_hit;
        if (bus_take) begin
            next_state.wr_addr = bus_addr;
            next_state.rdata   = hwrite ? 32'h00000000 : read_word;
        end
        if (state.wr_pend && state.wr_addr == REG_DIR_MASK) begin
            next_state.dir_mask = hwdata[15:0]; // RULE11
        end
        if (core_acc_we) begin
            next_state.acc = core_acc_data;
        end
        // an instruction of this group wins over the rest of the core
        if (is_in_c || is_in_d) begin
            next_state.acc  = port_sample; // RULE2 RULE3
            next_state.zero = port_sample == 4'h0; // RULE12
        end
        if (is_out_a) begin
            next_state.out_latch[PORT_A] = mem_rdata; // RULE6
        end
        if (is_out_b) begin
            next_state.out_latch[PORT_B] = mem_rdata; // RULE7
        end
        if (is_out_c) begin
            next_state.out_latch[PORT_C] = mem_rdata; // RULE8
        end
        if (is_out_d) begin
            next_state.out_latch[PORT_D] = mem_rdata; // RULE9
        end
        if (is_set_wake) begin
            next_state.wake_en = instr[SEF_LSB +: NIBBLE_W]; // RULE10
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state.acc       <= 4'h0;
            state.zero      <= 1'b0;
            state.wake_en   <= WAKE_ENABLE_RESET;
            state.dir_mask  <= {PORTS{DIR_MASK_RESET}}; // RULE11
            state.out_latch <= {PORTS{LATCH_RESET}};
            state.wr_pend   <= 1'b0;
            state.wr_addr   <= 8'h00;
            state.rdata     <= 32'h00000000;
        end else begin
            state <= next_state;
        end
    end

    // pins: mask bit 0 drives, and oe_n is low while driving
    genvar p;
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            assign pin_drive[p].data = state.out_latch[p];
            assign pin_drive[p].oe_n = state.dir_mask[p]; // RULE11
        end
    endgenerate

    assign accumulator           = state.acc;
    assign zero_flag             = state.zero;
    assign stop_wake_edge_enable = state.wake_en;
    assign hreadyout             = 1'b1;
    assign hrdata                = state.rdata;
    assign hresp                 = 1'b0;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_acc_store: assert property ( // RULE1
        is_store_acc |-> mem_we && mem_wdata == accumulator
                         && u_mem.write_addr == instr[6:0])
        else $error("accumulator store not written");
    a_port_c_load: assert property ( // RULE2
        is_in_c |=> accumulator == $past(pin_in[PORT_C])
                    && zero_flag == ($past(pin_in[PORT_C]) == 4'h0))
        else $error("port_c load wrong");
    a_port_d_load: assert property ( // RULE3
        is_in_d |=> accumulator == $past(pin_in[PORT_D])
                    && zero_flag == ($past(pin_in[PORT_D]) == 4'h0))
        else $error("port_d load wrong");
    a_port_c_mem: assert property ( // RULE2
        is_in_c |-> mem_we && mem_wdata == pin_in[PORT_C]
                    && u_mem.write_addr == instr[6:0])
        else $error("port_c nibble not stored");
    a_port_d_mem: assert property ( // RULE3
        is_in_d |-> mem_we && mem_wdata == pin_in[PORT_D]
                    && u_mem.write_addr == instr[6:0])
        else $error("port_d nibble not stored");

    // the accumulator holds unless a port-input move or a core write loads it
    a_acc_hold: assert property ( // RULE2
        !is_in_c && !is_in_d && !core_acc_we |=> $stable(accumulator))
        else $error("accumulator moved without a load");
    a_wr_copy: assert property ( // RULE4
        is_store_wr |-> mem_we
                        && mem_raddr == {3'h0, instr[11:8]})
        else $error("working register copy wrong");
    a_imm_store: assert property ( // RULE5
        is_store_imm |-> mem_we && mem_wdata == instr[10:7])
        else $error("immediate store wrong");
    a_imm_addr: assert property ( // RULE5
        is_store_imm |-> u_mem.write_addr == instr[6:0])
        else $error("immediate store misplaced");
    a_wr_source: assert property ( // RULE4
        is_store_wr |-> mem_wdata == mem_rdata
                        && u_mem.write_addr == instr[6:0])
        else $error("working register copy misplaced");
    // a stray write would corrupt a working register silently
    a_mem_quiet: assert property ( // RULE1
        !(is_store_acc || is_in_c || is_in_d || is_store_wr || is_store_imm)
            |-> !mem_we)
        else $error("memory written outside a store");
    a_port_a_out: assert property ( // RULE6
        is_out_a |=> pin_drive[PORT_A].data == $past(mem_rdata))
        else $error("port_a latch wrong");
    a_port_b_out: assert property ( // RULE7
        is_out_b |=> pin_drive[PORT_B].data == $past(mem_rdata))
        else $error("port_b latch wrong");
    a_port_c_out: assert property ( // RULE8
        is_out_c |=> pin_drive[PORT_C].data == $past(mem_rdata))
        else $error("port_c latch wrong");
    a_port_d_out: assert property ( // RULE9
        is_out_d |=> pin_drive[PORT_D].data == $past(mem_rdata))
        else $error("port_d latch wrong");

    a_port_a_hold: assert property ( // RULE6
        !is_out_a |=> $stable(pin_drive[PORT_A].data))
        else $error("port_a latch moved");
    a_port_b_hold: assert property ( // RULE7
        !is_out_b |=> $stable(pin_drive[PORT_B].data))
        else $error("port_b latch moved");
    a_port_c_hold: assert property ( // RULE8
        !is_out_c |=> $stable(pin_drive[PORT_C].data))
        else $error("port_c latch moved");
    a_port_d_hold: assert property ( // RULE9
        !is_out_d |=> $stable(pin_drive[PORT_D].data))
        else $error("port_d latch moved");
    a_latch_read: assert property ( // RULE6
        bus_take && !hwrite && addr_hit && bus_addr == REG_OUT_LATCH
            |=> hrdata[15:0] == $past({pin_drive[PORT_D].data,
                                       pin_drive[PORT_C].data,
                                       pin_drive[PORT_B].data,
                                       pin_drive[PORT_A].data}))
        else $error("latch read wrong");
    a_wake_set: assert property ( // RULE10
        is_set_wake ##1 !is_set_wake [*2]
            |-> stop_wake_edge_enable == $past(instr[3:0], 2))
        else $error("wake enables not held");

    a_wake_en_hold: assert property ( // RULE10
        !is_set_wake |=> $stable(stop_wake_edge_enable))
        else $error("wake enables moved");
    a_wake_in_stop: assert property ( // RULE10
        wake_request |-> $past(stop_mode))
        else $error("wake request outside stop mode");
    a_wake_masked: assert property ( // RULE10
        wake_request |-> ($past(stop_wake_edge_enable)
                          & ~$past(pin_in[PORT_C])) != 4'h0)
        else $error("wake request without enabled fall");
    a_wake_fires: assert property ( // RULE10
        stop_mode && (stop_wake_edge_enable & $past(pin_in[PORT_C])
                      & ~pin_in[PORT_C]) != 4'h0 |=> wake_request)
        else $error("enabled falling edge did not wake");
    a_mask_reset: assert property ( // RULE11
        $rose(!reset) |-> pin_drive[PORT_A].oe_n == 4'hF
                          && pin_drive[PORT_B].oe_n == 4'hF
                          && pin_drive[PORT_C].oe_n == 4'hF
                          && pin_drive[PORT_D].oe_n == 4'hF)
        else $error("mask not all ones after reset");
    // masks show two edges after the address phase
    a_mask_write: assert property ( // RULE11
        bus_take && hwrite && addr_hit && bus_addr == REG_DIR_MASK
            |=> ##1 {pin_drive[PORT_D].oe_n, pin_drive[PORT_C].oe_n,
                     pin_drive[PORT_B].oe_n, pin_drive[PORT_A].oe_n}
                    == $past(hwdata[15:0]))
        else $error("direction masks not written");
    a_mask_read: assert property ( // RULE11
        bus_take && !hwrite && addr_hit && bus_addr == REG_DIR_MASK
            |=> hrdata == {16'h0000, $past(state.dir_mask)})
        else $error("direction mask read wrong");
    a_zero_hold: assert property ( // RULE12
        !is_in_c && !is_in_d |=> $stable(zero_flag))
        else $error("zero flag moved without input move");
    a_state_read: assert property ( // RULE12
        bus_take && !hwrite && addr_hit && bus_addr == REG_CORE_STATE
            |=> hrdata[4:0] == $past({zero_flag, accumulator}))
        else $error("core state read wrong");

    c_input_zero: cover property (is_in_c && pin_in[PORT_C] == 4'h0);
    c_acc_race: cover property (is_in_c && core_acc_we);
    c_wr_copy: cover property (is_store_wr);
    c_wake: cover property (is_set_wake ##[1:20] wake_request);
    c_out_driven: cover property (
        is_out_a ##[1:10] pin_drive[PORT_A].oe_n != 4'hF);
endmodule
`default_nettype wire

// ### test/pin_circuit.sv
// external pin circuitry: resolves port latches against outside levels
`timescale 1ns/100ps
`default_nettype none
module pin_circuit
    import move_ops_pkg::*;
(
    input  wire port_drive_t   drive [PORTS],
    input  wire port_nibbles_t ext_level,
    output port_nibbles_t      pin_level
);
    // a pin reads back its own latch only while the device drives it
    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            for (int b = 0; b < NIBBLE_W; b++) begin
                pin_level[p][b] = drive[p].oe_n[b] ? ext_level[p][b]
                                                   : drive[p].data[b];
            end
        end
    end
endmodule
`default_nettype wire

// ### test/port_and_memory_move_ops_tb.sv
// self-checking bench for the data-move instruction group
`timescale 1ns/100ps
`default_nettype none
module port_and_memory_move_ops_tb
    import move_ops_pkg::*;
();
    logic          clk_sys;
    logic          reset;
    logic          instr_valid;
    logic [15:0]   instr;
    logic          core_acc_we;
    nibble_t       core_acc_data;
    logic          stop_mode;
    port_nibbles_t pin_in;
    port_nibbles_t ext_level;
    port_drive_t   pin_drive [PORTS];
    nibble_t       accumulator;
    logic          zero_flag;
    nibble_t       stop_wake_edge_enable;
    logic          wake_request;
    logic          hsel;
    logic [31:0]   haddr;
    logic [1:0]    htrans;
    logic          hwrite;
    logic [2:0]    hsize;
    logic [31:0]   hwdata;
    logic          hreadyout;
    logic [31:0]   hrdata;
    logic          hresp;
    logic [31:0]   rd;
    int            err_total;
    int            tests_run;
    int            seen;

    port_and_memory_move_ops u_port_and_memory_move_ops (
        .clk_sys(clk_sys),
        .reset(reset),
        .instr_valid(instr_valid),
        .instr(instr),
        .core_acc_we(core_acc_we),
        .core_acc_data(core_acc_data),
        .stop_mode(stop_mode),
        .pin_in(pin_in),
        .pin_drive(pin_drive),
        .accumulator(accumulator),
        .zero_flag(zero_flag),
        .stop_wake_edge_enable(stop_wake_edge_enable),
        .wake_request(wake_request),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp)
    );

    pin_circuit u_pin_circuit (
        .drive(pin_drive),
        .ext_level(ext_level),
        .pin_level(pin_in)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // single word transfer; read data is taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel   <= 1'h1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        do @(posedge clk_sys); while (hreadyout !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask

    task automatic issue(input logic [15:0] w);
        instr       <= w;
        instr_valid <= 1'h1;
        @(posedge clk_sys);
    endtask

    // one spare edge so registered results have landed
    task automatic idle();
        instr_valid <= 1'h0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic watch(input nibble_t lvl);
        ext_level[PORT_C] <= lvl;
        seen = 0;
        repeat (4) begin
            @(posedge clk_sys);
            #1;
            if (wake_request === 1'h1)
                seen++;
        end
    endtask

    task automatic results();
        $display("counts: %0d checks, %0d mismatches", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    // the whole sequence needs well under 200 cycles
    initial begin
        #20000;
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end

    initial begin
        err_total = 0;
        tests_run = 0;
        seen = 0;
        rd = 32'h0;
        reset = 1'h1;
        instr_valid = 1'h0;
        instr = 16'h0;
        core_acc_we = 1'h0;
        core_acc_data = 4'h0;
        stop_mode = 1'h0;
        ext_level = 16'hFFFF;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h0;
        hwdata = 32'h0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'h0;
        idle();
        for (int p = 0; p < PORTS; p++)
            chk(pin_drive[p].oe_n, 4'hF);
        bus(1'h0, REG_DIR_MASK, 32'h0);
        chk(rd, 32'h0000FFFF);
        bus(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        chk(hresp, 1'h0);
        bus(1'h1, REG_DIR_MASK, 32'h0000FF00);
        idle();
        chk(pin_drive[PORT_A].oe_n, 4'h0);
        chk(pin_drive[PORT_C].oe_n, 4'hF);
        $display("test reset and masks done");
        issue({OP_STORE_IMM, 4'hA, 7'h05});
        issue({OP_OUT_A, 7'h05});
        idle();
        chk(pin_drive[PORT_A].data, 4'hA);
        ext_level[PORT_D] <= 4'h6;
        ext_level[PORT_C] <= 4'h0;
        idle();
        issue({OP_IN_PORT_D, 7'h12});
        idle();
        chk(accumulator, 4'h6);
        chk(zero_flag, 1'h0);
        issue({OP_IN_PORT_C, 7'h11});
        issue({OP_OUT_B, 7'h12});
        idle();
        chk(accumulator, 4'h0);
        chk(zero_flag, 1'h1);
        chk(pin_drive[PORT_B].data, 4'h6);
        issue({OP_OUT_B, 7'h11});
        idle();
        chk(pin_drive[PORT_B].data, 4'h0);
        core_acc_data <= 4'h3;
        core_acc_we   <= 1'h1;
        issue({OP_IN_PORT_C, 7'h13});
        core_acc_we   <= 1'h0;
        idle();
        chk(accumulator, 4'h0);
        chk(zero_flag, 1'h1);
        $display("test port moves done");
        core_acc_data <= 4'h9;
        core_acc_we   <= 1'h1;
        @(posedge clk_sys);
        core_acc_we   <= 1'h0;
        issue({OP_STORE_ACC, 7'h20});
        issue({OP_OUT_C, 7'h20});
        idle();
        chk(pin_drive[PORT_C].data, 4'h9);
        bus(1'h0, REG_OUT_LATCH, 32'h0);
        chk(rd, 32'h0000090A);
        issue({OP_STORE_IMM, 4'hC, 7'h03});
        issue({OP_STORE_WR, 4'h3, 1'h0, 7'h40});
        issue({OP_OUT_D, 7'h40});
        idle();
        chk(pin_drive[PORT_D].data, 4'hC);
        $display("test stores done");
        issue({OP_SET_WAKE, 4'h5});
        idle();
        chk(stop_wake_edge_enable, 4'h5);
        bus(1'h0, REG_CORE_STATE, 32'h0);
        chk(rd, 32'h00000519);
        watch(4'hF);
        stop_mode <= 1'h1;
        watch(4'hE);
        chk(seen != 0, 1'h1);
        watch(4'hC);
        chk(seen, 0);
        $display("test wake done");
        stop_mode <= 1'h0;
        reset     <= 1'h1;
        repeat (2) @(posedge clk_sys);
        reset     <= 1'h0;
        idle();
        for (int p = 0; p < PORTS; p++)
            chk(pin_drive[p].oe_n, 4'hF);
        chk(pin_drive[PORT_C].data, 4'h0);
        chk(stop_wake_edge_enable, 4'h0);
        chk(accumulator, 4'h0);
        $display("test mid-run reset done");
        results();
    end
endmodule
`default_nettype wire
